/* rtl/pmcs_regs.sv */
// Behaviour
// - Disabled monitor: pulldown, or float if set
// - Monitor select code routes chosen rail
// - Drive codes 00/01 pull up/down statically
// - Drive code 10 follows control input
// - Drive code 11 inverts control input
// - Pull mode enables up/down structures
// - Exact codes trigger power off/hard reset
// - Status bits 7/6 show undervoltage
// - Bits 5/4 thermal, 3/2 current mode
// - Status bit 1 shows button level
// - Status bit 0 shows control input level
// - Short press wakes from off unless a power off pulse falls in the same cycle
`timescale 1ns/1ps
`include "pmcs_defines.svh"
module pmcs_regs #(
	parameter logic [6:0] DEV_ADDR = `PMCS_I2C_ADDR,
	parameter bit BUTTON_ACTIVE_LOW = 1'b1
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic push_button_input,
	input wire logic multipurpose_control_input,
	input wire logic linreg2_undervoltage,
	input wire logic linreg1_undervoltage,
	input wire logic linreg2_thermal_shutdown,
	input wire logic linreg1_thermal_shutdown,
	input wire logic linreg2_current_mode,
	input wire logic linreg1_current_mode,
	output logic [2:0] monitor_source_select,
	output logic monitor_pulldown_en,
	output logic monitor_float,
	output logic mpo_pullup_en,
	output logic mpo_pulldown_en,
	output logic power_off_pulse,
	output logic hard_reset_pulse,
	output logic soft_reset_pulse,
	output logic wake_pulse,
	output logic device_off
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic scl;
	logic sda;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	pmcs_pkg::pmcs_i2c_state_e state_q;
	logic [3:0] bit_cnt_q;
	logic ack_phase_q;
	logic [7:0] shreg_q;
	logic [7:0] tx_q;
	logic [7:0] ptr_q;
	logic rw_q;
	logic nack_q;
	logic sda_oe_q;
	logic sda_o_q;
	logic byte_end;
	logic wr_en;
	logic cmd_wr;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] status;
	logic [7:0] mon_cfg_q;
	logic [7:0] mpo_cfg_q;
	logic [7:0] power_cmd_q;
	logic [2:0] mon_sel_q;
	logic mon_pd_q;
	logic mon_float_q;
	logic want_up;
	logic pullup_q;
	logic pulldown_q;
	logic power_off_q;
	logic hard_reset_q;
	logic soft_reset_q;
	logic wake_q;
	logic device_off_q;
	logic btn_pressed;
	logic btn_prev_q;
	logic press_edge;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Pin synchronisers; low byte is the live status byte
	pmcs_sync_if #(.W(`PMCS_SYNC_W)) sync_bus ();
	assign sync_bus.raw = {scl_i, sda_i,
		linreg2_undervoltage, linreg1_undervoltage,
		linreg2_thermal_shutdown, linreg1_thermal_shutdown,
		linreg2_current_mode, linreg1_current_mode,
		push_button_input, multipurpose_control_input};

	pmcs_sync #(.W(`PMCS_SYNC_W), .INIT(`PMCS_SYNC_INIT)) u_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.port(sync_bus.filt)
	);

	assign scl = sync_bus.clean[`PMCS_SYNC_SCL];
	assign sda = sync_bus.clean[`PMCS_SYNC_SDA];
	assign status = sync_bus.clean[7:0];

	// Bus condition detection
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl;
			sda_prev_q <= sda;
		end
	end
	assign scl_rise = scl & ~scl_prev_q;
	assign scl_fall = ~scl & scl_prev_q;
	assign start_det = scl & scl_prev_q & sda_prev_q & ~sda;
	assign stop_det = scl & scl_prev_q & ~sda_prev_q & sda;
	assign byte_end = scl_fall & (bit_cnt_q == `PMCS_BITS_PER_BYTE) & ~ack_phase_q
		& ~start_det & ~stop_det;
	assign wr_en = byte_end & (state_q == pmcs_pkg::ST_WDAT);
	assign cmd_wr = wr_en & (ptr_q == `PMCS_REG_CMD);

	// Register read mux
	assign rd_addr = (state_q == pmcs_pkg::ST_RDAT) ? ptr_q + 8'h01 : ptr_q;
	always_comb begin
		case (rd_addr)
			`PMCS_REG_MON: rd_data = mon_cfg_q;
			`PMCS_REG_MPO: rd_data = mpo_cfg_q;
			`PMCS_REG_CMD: rd_data = power_cmd_q;
			`PMCS_REG_STS: rd_data = status;
			default: rd_data = `PMCS_REG_NONE;
		endcase
	end

	// Serial slave state machine
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= pmcs_pkg::ST_IDLE;
			bit_cnt_q <= `PMCS_BIT_ZERO;
			ack_phase_q <= 1'b0;
			shreg_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (start_det) begin
			state_q <= pmcs_pkg::ST_DEV;
			bit_cnt_q <= `PMCS_BIT_ZERO;
			ack_phase_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (stop_det) begin
			state_q <= pmcs_pkg::ST_IDLE;
			bit_cnt_q <= `PMCS_BIT_ZERO;
			ack_phase_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (state_q != pmcs_pkg::ST_IDLE) begin
			if (scl_rise) begin
				if (bit_cnt_q != `PMCS_BITS_PER_BYTE) begin
					shreg_q <= {shreg_q[6:0], sda};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end else if (state_q == pmcs_pkg::ST_RDAT) begin
					nack_q <= sda;
				end
			end else if (byte_end) begin
				ack_phase_q <= 1'b1;
				case (state_q)
					pmcs_pkg::ST_DEV: begin
						if (shreg_q[7:1] == DEV_ADDR) begin
							sda_oe_q <= 1'b1;
							rw_q <= shreg_q[0];
						end else begin
							state_q <= pmcs_pkg::ST_IDLE;
							sda_oe_q <= 1'b0;
						end
					end
					pmcs_pkg::ST_PTR: begin
						sda_oe_q <= 1'b1;
						ptr_q <= shreg_q;
					end
					pmcs_pkg::ST_WDAT: begin
						sda_oe_q <= 1'b1;
						ptr_q <= ptr_q + 8'h01;
					end
					default: begin
						sda_oe_q <= 1'b0;
					end
				endcase
			end else if (scl_fall && ack_phase_q) begin
				ack_phase_q <= 1'b0;
				bit_cnt_q <= `PMCS_BIT_ZERO;
				case (state_q)
					pmcs_pkg::ST_DEV: begin
						if (rw_q) begin
							state_q <= pmcs_pkg::ST_RDAT;
							tx_q <= rd_data;
							sda_oe_q <= ~rd_data[7];
						end else begin
							state_q <= pmcs_pkg::ST_PTR;
							sda_oe_q <= 1'b0;
						end
					end
					pmcs_pkg::ST_PTR: begin
						state_q <= pmcs_pkg::ST_WDAT;
						sda_oe_q <= 1'b0;
					end
					pmcs_pkg::ST_RDAT: begin
						if (nack_q) begin
							state_q <= pmcs_pkg::ST_IDLE;
							sda_oe_q <= 1'b0;
						end else begin
							ptr_q <= ptr_q + 8'h01;
							tx_q <= rd_data;
							sda_oe_q <= ~rd_data[7];
						end
					end
					default: begin
						sda_oe_q <= 1'b0;
					end
				endcase
			end else if (scl_fall && state_q == pmcs_pkg::ST_RDAT) begin
				tx_q <= {tx_q[6:0], 1'b0};
				sda_oe_q <= ~tx_q[6];
			end
		end
	end

	// Open-drain data only ever pulls low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_o_q <= 1'b0;
		end else begin
			sda_o_q <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mon_cfg_q <= `PMCS_MON_RST;
			mpo_cfg_q <= `PMCS_MPO_RST;
			power_cmd_q <= `PMCS_CMD_RST;
		end else if (wr_en) begin
			if (ptr_q == `PMCS_REG_MON) begin
				mon_cfg_q <= shreg_q & `PMCS_MON_MASK;
			end
			if (ptr_q == `PMCS_REG_MPO) begin
				mpo_cfg_q <= shreg_q & `PMCS_MPO_MASK;
			end
			if (ptr_q == `PMCS_REG_CMD) begin
				power_cmd_q <= shreg_q;
			end
		end
	end

	// Monitor multiplexer controls
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mon_sel_q <= `PMCS_MON_SEL_RST;
			mon_pd_q <= 1'b0;
			mon_float_q <= 1'b0;
		end else begin
			mon_sel_q <= mon_cfg_q[`PMCS_MON_SEL_MSB:`PMCS_MON_SEL_LSB];
			mon_pd_q <= (mon_cfg_q[`PMCS_MON_SEL_MSB:`PMCS_MON_SEL_LSB] == `PMCS_MON_SEL_OFF)
				& ~mon_cfg_q[`PMCS_MON_FLOAT_BIT];
			mon_float_q <= (mon_cfg_q[`PMCS_MON_SEL_MSB:`PMCS_MON_SEL_LSB] == `PMCS_MON_SEL_OFF)
				& mon_cfg_q[`PMCS_MON_FLOAT_BIT];
		end
	end

	// Multipurpose output direction
	always_comb begin
		case (mpo_cfg_q[`PMCS_MPO_DRV_MSB:`PMCS_MPO_DRV_LSB])
			`PMCS_DRV_UP: want_up = 1'b1;
			`PMCS_DRV_DOWN: want_up = 1'b0;
			`PMCS_DRV_FOLLOW: want_up = status[`PMCS_STS_CONTROL];
			`PMCS_DRV_INVERT: want_up = ~status[`PMCS_STS_CONTROL];
			default: want_up = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pullup_q <= 1'b0;
			pulldown_q <= 1'b0;
		end else begin
			pullup_q <= want_up & mpo_cfg_q[`PMCS_MPO_PULL_UP_BIT];
			pulldown_q <= ~want_up & mpo_cfg_q[`PMCS_MPO_PULL_DN_BIT];
		end
	end

	// Power command decode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_off_q <= 1'b0;
			hard_reset_q <= 1'b0;
			soft_reset_q <= 1'b0;
		end else begin
			power_off_q <= cmd_wr & (shreg_q == `PMCS_CMD_POWER_OFF);
			hard_reset_q <= cmd_wr & (shreg_q == `PMCS_CMD_HARD_RESET);
			soft_reset_q <= cmd_wr & (shreg_q == `PMCS_CMD_SOFT_RESET);
		end
	end

	// Off state and button wake
	assign btn_pressed = BUTTON_ACTIVE_LOW ? ~status[`PMCS_STS_BUTTON] : status[`PMCS_STS_BUTTON];
	assign press_edge = btn_pressed & ~btn_prev_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			btn_prev_q <= 1'b1;
			device_off_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			btn_prev_q <= btn_pressed;
			wake_q <= device_off_q & press_edge & ~power_off_q;
			if (power_off_q) begin
				device_off_q <= 1'b1;
			end else if (press_edge) begin
				device_off_q <= 1'b0;
			end
		end
	end

	assign sda_o = sda_o_q;
	assign sda_oe = sda_oe_q;
	assign monitor_source_select = mon_sel_q;
	assign monitor_pulldown_en = mon_pd_q;
	assign monitor_float = mon_float_q;
	assign mpo_pullup_en = pullup_q;
	assign mpo_pulldown_en = pulldown_q;
	assign power_off_pulse = power_off_q;
	assign hard_reset_pulse = hard_reset_q;
	assign soft_reset_pulse = soft_reset_q;
	assign wake_pulse = wake_q;
	assign device_off = device_off_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_mon_off_pulldown: assert property (mon_cfg_q[3:0] == 4'h0 |=>
		(monitor_pulldown_en && !monitor_float)) else $error("monitor pulldown missing");
	chk_mon_off_float: assert property (mon_cfg_q[3:0] == 4'h8 [*2] |=>
		(monitor_float && !monitor_pulldown_en)) else $error("monitor not floating");
	chk_mon_route_sel: assert property (mon_cfg_q[2:0] != 3'h0 |=>
		(monitor_source_select == $past(mon_cfg_q[2:0]) && !monitor_pulldown_en
		&& !monitor_float)) else $error("monitor route wrong");
	chk_mpo_static_drive: assert property (mpo_cfg_q == 8'h03 |=>
		(mpo_pullup_en && !mpo_pulldown_en)) else $error("static pull up wrong");
	chk_mpo_static_down: assert property (mpo_cfg_q == 8'h43 |=>
		(mpo_pulldown_en && !mpo_pullup_en)) else $error("static pull down wrong");
	chk_mpo_follow_in: assert property (mpo_cfg_q == 8'h83 |=>
		(mpo_pullup_en == $past(status[0]) && mpo_pulldown_en == !$past(status[0])))
		else $error("follow mode wrong");
	chk_mpo_invert_in: assert property (mpo_cfg_q == 8'hC3 |=>
		(mpo_pullup_en == !$past(status[0]) && mpo_pulldown_en == $past(status[0])))
		else $error("invert mode wrong");
	chk_mpo_pull_off: assert property (mpo_cfg_q[1:0] == 2'h0 |=>
		(!mpo_pullup_en && !mpo_pulldown_en)) else $error("pull disabled but driving");
	chk_cmd_power_off: assert property (cmd_wr && shreg_q == 8'hB2 |=>
		power_off_pulse ##1 (!power_off_pulse && device_off)) else $error("power off lost");
	chk_cmd_hard_reset: assert property (cmd_wr && shreg_q == 8'hC3 |=>
		(hard_reset_pulse && !power_off_pulse)) else $error("hard reset lost");
	chk_cmd_unknown_ignored: assert property (!(cmd_wr && (shreg_q == 8'hB2
		|| shreg_q == 8'hC3 || shreg_q == 8'h5A)) |=> (!power_off_pulse && !hard_reset_pulse
		&& !soft_reset_pulse)) else $error("action without valid code");
	chk_status_read_live: assert property (state_q == pmcs_pkg::ST_DEV && ack_phase_q
		&& scl_fall && rw_q && ptr_q == 8'h0F && !start_det && !stop_det
		|=> tx_q == $past(sync_bus.clean[7:0])) else $error("status byte wrong");
	chk_wake_short_press: assert property (device_off_q && press_edge && !power_off_q
		|=> (wake_pulse && !device_off)) else $error("button did not wake");

	cov_power_off: cover property (power_off_pulse);
	cov_status_read: cover property (state_q == pmcs_pkg::ST_RDAT && ptr_q == 8'h0F);
	cov_wake: cover property (wake_pulse);
	cov_follow_active: cover property (mpo_cfg_q == 8'h83 && mpo_pullup_en);
endmodule

/* rtl/pmcs_sync.sv */
`timescale 1ns/1ps
module pmcs_sync #(
	parameter int W = 10,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	pmcs_sync_if.filt port
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] clean_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
		end else begin
			s1_q <= port.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Bit changes only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clean_q <= INIT;
		end else begin
			clean_q <= (s2_q & s3_q) | (clean_q & (s2_q ^ s3_q));
		end
	end

	assign port.clean = clean_q;
endmodule

/* shared/pmcs_defines.svh */
`ifndef PMCS_DEFINES_SVH
`define PMCS_DEFINES_SVH

// Register offsets
`define PMCS_REG_MON 8'h0C
`define PMCS_REG_MPO 8'h0D
`define PMCS_REG_CMD 8'h0E
`define PMCS_REG_STS 8'h0F
`define PMCS_REG_NONE 8'h00

// Reset values and writable masks
`define PMCS_MON_RST 8'h00
`define PMCS_MPO_RST 8'h00
`define PMCS_CMD_RST 8'h00
`define PMCS_MON_MASK 8'h0F
`define PMCS_MPO_MASK 8'hC3

// Monitor fields
`define PMCS_MON_FLOAT_BIT 3
`define PMCS_MON_SEL_MSB 2
`define PMCS_MON_SEL_LSB 0
`define PMCS_MON_SEL_OFF 3'h0
`define PMCS_MON_SEL_RST 3'h0

// Multipurpose output fields
`define PMCS_MPO_DRV_MSB 7
`define PMCS_MPO_DRV_LSB 6
`define PMCS_MPO_PULL_UP_BIT 1
`define PMCS_MPO_PULL_DN_BIT 0
`define PMCS_DRV_UP 2'h0
`define PMCS_DRV_DOWN 2'h1
`define PMCS_DRV_FOLLOW 2'h2
`define PMCS_DRV_INVERT 2'h3

// Power command codes
`define PMCS_CMD_POWER_OFF 8'hB2
`define PMCS_CMD_HARD_RESET 8'hC3
`define PMCS_CMD_SOFT_RESET 8'h5A

// Synchroniser vector layout, low byte is the status byte
`define PMCS_SYNC_W 10
`define PMCS_SYNC_SCL 9
`define PMCS_SYNC_SDA 8
`define PMCS_STS_BUTTON 1
`define PMCS_STS_CONTROL 0
`define PMCS_SYNC_INIT 10'h300

// Serial link
`define PMCS_I2C_ADDR 7'h30
`define PMCS_BITS_PER_BYTE 4'h8
`define PMCS_BIT_ZERO 4'h0

`endif

/* shared/pmcs_pkg.sv */
package pmcs_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_DEV = 5'h02,
		ST_PTR = 5'h04,
		ST_WDAT = 5'h08,
		ST_RDAT = 5'h10
	} pmcs_i2c_state_e;
endpackage

/* shared/pmcs_sync_if.sv */
`timescale 1ns/1ps
interface pmcs_sync_if #(parameter int W = 10);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface

/* testbench/pmcs_host_model.sv */
`timescale 1ns/1ps
`include "pmcs_defines.svh"
module pmcs_host_model (
	input wire logic core_clk,
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	localparam int HALF = 40;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic start_cond();
		sda_drv = 1'b1;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_drv = 1'b0;
		tick(HALF);
		scl = 1'b0;
		tick(HALF);
	endtask
	task automatic stop_cond();
		sda_drv = 1'b0;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_drv = 1'b1;
		tick(HALF);
	endtask
	task automatic bit_io(input logic b, output logic s);
		sda_drv = b;
		tick(HALF);
		scl = 1'b1;
		tick(HALF / 2);
		s = sda;
		tick(HALF / 2);
		scl = 1'b0;
		tick(HALF / 2);
	endtask
	task automatic byte_out(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = (s === 1'b0);
	endtask
	task automatic byte_in(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, s);
	endtask
	// Whole byte values only
	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] val, output logic ok);
		logic a0, a1, a2;
		start_cond();
		byte_out({`PMCS_I2C_ADDR, 1'b0}, a0);
		byte_out(ptr, a1);
		byte_out(val, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask
	task automatic read_regs(input logic [7:0] ptr, input int n, output logic [7:0] d [4],
		output logic ok);
		logic a0, a1, a2;
		start_cond();
		byte_out({`PMCS_I2C_ADDR, 1'b0}, a0);
		byte_out(ptr, a1);
		start_cond();
		byte_out({`PMCS_I2C_ADDR, 1'b1}, a2);
		for (int i = 0; i < n; i++) begin
			byte_in(i == n - 1, d[i]);
		end
		stop_cond();
		ok = a0 & a1 & a2;
	endtask
endmodule

/* testbench/test_pmic_monitor_output_command_status_regs.sv */
`timescale 1ns/1ps
`include "pmcs_defines.svh"
module test_pmic_monitor_output_command_status_regs;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic scl, sda_drv, sda_w, sda_o, sda_oe;
	logic [5:0] flt = 6'h29;
	logic button = 1'b0;
	logic ctrl = 1'b1;
	logic [2:0] mon_sel;
	logic mon_pd, mon_fl, pu, pd, p_off, p_hard, p_soft, p_wake, dev_off, ok;
	logic [7:0] rd [4];
	logic [7:0] mon_vals [5] = '{8'hF0, 8'h08, 8'h01, 8'h02, 8'hFB};
	logic [7:0] mpo_vals [8] = '{8'h03, 8'h43, 8'h83, 8'h00, 8'h02, 8'h41, 8'h42, 8'hFF};
	logic [7:0] cmd_vals [4] = '{`PMCS_CMD_SOFT_RESET, 8'h12, 8'hC3, 8'hB2};
	int n_errors = 0;
	int comparisons = 0;
	int n_off = 0, n_hard = 0, n_soft = 0, n_wake = 0, e_off = 0, e_hard = 0, e_soft = 0;
	assign sda_w = sda_drv & ~sda_oe;
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	pmcs_regs u_pmcs_regs (.core_clk(core_clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe), .push_button_input(button),
		.multipurpose_control_input(ctrl), .linreg2_undervoltage(flt[5]),
		.linreg1_undervoltage(flt[4]), .linreg2_thermal_shutdown(flt[3]),
		.linreg1_thermal_shutdown(flt[2]), .linreg2_current_mode(flt[1]),
		.linreg1_current_mode(flt[0]), .monitor_source_select(mon_sel),
		.monitor_pulldown_en(mon_pd), .monitor_float(mon_fl), .mpo_pullup_en(pu),
		.mpo_pulldown_en(pd), .power_off_pulse(p_off), .hard_reset_pulse(p_hard),
		.soft_reset_pulse(p_soft), .wake_pulse(p_wake), .device_off(dev_off));
	pmcs_host_model u_pmcs_host_model (.core_clk(core_clk), .scl(scl), .sda_drv(sda_drv),
		.sda(sda_w));
	always @(posedge core_clk) begin
		n_off += (p_off === 1'b1);
		n_hard += (p_hard === 1'b1);
		n_soft += (p_soft === 1'b1);
		n_wake += (p_wake === 1'b1);
	end
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check1(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
		u_pmcs_host_model.write_reg(ptr, val, ok);
		check1("write_ack", 1'b1, ok);
	endtask
	task automatic settle_in(input logic b, input logic c);
		@(posedge core_clk);
		#1;
		button = b;
		ctrl = c;
		repeat (8) @(posedge core_clk);
		#1;
	endtask
	function automatic logic [1:0] mpo_exp(input logic [7:0] v, input logic c);
		logic up;
		up = v[7:6] == 2'h0 || (v[7:6] == 2'h2 && c) || (v[7:6] == 2'h3 && !c);
		return {up & v[1], !up & v[0]};
	endfunction
	task automatic results();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		results();
	end
	initial begin
		logic [1:0] e;
		repeat (4) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		repeat (20) @(posedge core_clk);
		u_pmcs_host_model.read_regs(8'h0C, 4, rd, ok);
		check1("read_ack", 1'b1, ok);
		check8("mon_reset", 8'h00, rd[0]);
		check8("mpo_reset", 8'h00, rd[1]);
		check8("cmd_reset", 8'h00, rd[2]);
		check8("status_a", 8'hA5, rd[3]);
		check1("sda_o", 1'b0, sda_o);
		foreach (mon_vals[i]) begin
			wr(8'h0C, mon_vals[i]);
			check8("mon_sel", {5'h00, mon_vals[i][2:0]}, {5'h00, mon_sel});
			check1("mon_pulldown", mon_vals[i][3:0] == 4'h0, mon_pd);
			check1("mon_float", mon_vals[i][3:0] == 4'h8, mon_fl);
		end
		foreach (mpo_vals[i]) begin
			wr(8'h0D, mpo_vals[i]);
			for (int c = 0; c < 2; c++) begin
				settle_in(1'b0, c[0]);
				e = mpo_exp(mpo_vals[i], c[0]);
				check1("mpo_pullup", e[1], pu);
				check1("mpo_pulldown", e[0], pd);
			end
		end
		settle_in(1'b1, 1'b0);
		foreach (cmd_vals[i]) begin
			wr(8'h0E, cmd_vals[i]);
			repeat (4) @(posedge core_clk);
			e_off += (cmd_vals[i] == 8'hB2);
			e_hard += (cmd_vals[i] == 8'hC3);
			e_soft += (cmd_vals[i] == `PMCS_CMD_SOFT_RESET);
			check8("off_pulses", e_off[7:0], n_off[7:0]);
			check8("hard_pulses", e_hard[7:0], n_hard[7:0]);
			check8("soft_pulses", e_soft[7:0], n_soft[7:0]);
			check1("device_off", cmd_vals[i] == 8'hB2, dev_off);
		end
		check8("wake_before", 8'h00, n_wake[7:0]);
		settle_in(1'b0, 1'b0);
		check8("wake_pulses", 8'h01, n_wake[7:0]);
		check1("device_on", 1'b0, dev_off);
		settle_in(1'b1, 1'b0);
		flt = 6'h16;
		wr(8'h0F, 8'h00);
		wr(8'h3F, 8'hFF);
		u_pmcs_host_model.read_regs(8'h3F, 1, rd, ok);
		check1("read_ack", 1'b1, ok);
		check8("unmapped", 8'h00, rd[0]);
		u_pmcs_host_model.read_regs(8'h0C, 4, rd, ok);
		check8("mon_back", 8'h0B, rd[0]);
		check8("mpo_back", 8'hC3, rd[1]);
		check8("cmd_back", 8'hB2, rd[2]);
		check8("status_b", 8'h5A, rd[3]);
		u_pmcs_host_model.read_regs(8'h0F, 1, rd, ok);
		check1("read_ack", 1'b1, ok);
		check8("status_c", 8'h5A, rd[0]);
		results();
	end
endmodule
